// ===== design/rnb_scheduler.sv
`timescale 1ns/10ps
`include "rnb_cfg.svh"

module rnb_scheduler #(
  parameter int unsigned TICK_CYCLES = `RNB_TICK_MS * 1000 * `RNB_CLK_MHZ
) (
  // Clock and reset
  input  wire  logic                  clk,
  input  wire  logic                  rst,
  input  wire  logic                  ce,
  // Register bus
  input  wire  rnb_pkg::rnb_axi_req_s axi_req,
  output       rnb_pkg::rnb_axi_rsp_s axi_rsp,
  // Message queue
  input  wire  logic                  msg_valid,
  output       logic                  msg_ready,
  output       logic                  msg_err,
  // Modem link
  output       logic                  rts,
  input  wire  logic                  cts,
  output       rnb_pkg::rnb_tx_s      tx,
  input  wire  logic                  tx_done,
  input  wire  rnb_pkg::rnb_rx_s      rx,
  // Interrupt
  output       logic                  irq
);
  import rnb_pkg::*;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  typedef struct packed {
    rnb_state_e  st;
    logic        cts_s1;
    logic        cts_s2;
    logic [31:0] pre;
    logic [15:0] tmr;
    logic        rts;
    rnb_tx_s     tx;
    logic        err;
    logic        is_bid;
    logic [15:0] tries;
    logic [15:0] sent;
    logic        pause_pend;
    logic        bid_act;
    logic [6:0]  cur;
    logic [6:0]  base;
    logic [1:0]  ctrl;
    logic [7:0]  net_id;
    logic [15:0] cts_time;
    logic [15:0] resp_time;
    logic [15:0] bid_gap;
    logic [15:0] retries;
    logic [15:0] pause;
    logic [15:0] msg_count;
    logic [15:0] bid_addr;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        aw_got;
    logic [11:0] aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rnb_regs_s;

  rnb_regs_s st_q;
  rnb_regs_s st_d;

  // Map byte offset to register index, 4'hf when unmapped
  function automatic logic [3:0] reg_idx(input logic [31:0] a);
    if (a[31:12] != 20'h00000 || a[1:0] != 2'b00 ||
        a[11:0] > `RNB_OFF_IRQ_MASK)
      return 4'hf;
    return a[5:2];
  endfunction

  // Merge the two low write lanes into a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sb);
    merge16 = old;
    if (sb[0]) merge16[7:0] = wd[7:0];
    if (sb[1]) merge16[15:8] = wd[15:8];
  endfunction

  function automatic rnb_bid_e bid_mode(input logic [15:0] v);
    if (v >= `RNB_BID_LIMIT || v < `RNB_BID_SINGLE_LO)
      return RNB_BID_NONE;
    if (v >= `RNB_BID_LOOP_LO) return RNB_BID_LOOP;
    if (v >= `RNB_BID_CONT_LO) return RNB_BID_CONT;
    if (v >= `RNB_BID_DEC_LO) return RNB_BID_DEC;
    return RNB_BID_SINGLE;
  endfunction

  // Slave address carried by a bid setting
  function automatic logic [6:0] bid_base(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    case (bid_mode(v))
      RNB_BID_DEC:  r = v - `RNB_BID_DEC_LO;
      RNB_BID_CONT: r = v - `RNB_BID_CONT_LO;
      RNB_BID_LOOP: r = v - `RNB_BID_LOOP_LO;
      default:      r = v;
    endcase
    return r[6:0];
  endfunction

  // Enter transmission: pause first if owed, else raise RTS
  function automatic rnb_regs_s begin_tx(input rnb_regs_s s);
    begin_tx = s;
    begin_tx.pre = 32'h00000000;
    if (s.pause_pend) begin
      begin_tx.st  = RNB_PAUSE;
      begin_tx.tmr = s.pause;
    end else begin
      begin_tx.st  = RNB_RTS;
      begin_tx.rts = 1'b1;
      begin_tx.tmr = s.cts_time;
    end
  endfunction

  function automatic rnb_regs_s start_bid(input rnb_regs_s s,
                                          input logic [6:0] a);
    start_bid = s;
    start_bid.is_bid = 1'b1;
    start_bid.cur    = a;
    start_bid.tries  = 16'h0000;
    start_bid        = begin_tx(start_bid);
  endfunction

  function automatic rnb_regs_s start_gap(input rnb_regs_s s);
    start_gap = s;
    start_gap.st  = RNB_GAP;
    start_gap.pre = 32'h00000000;
    start_gap.tmr = s.bid_gap;
  endfunction

  logic        net_ok;
  logic        take_msg;
  logic [3:0]  ev;
  logic [3:0]  w1c;
  logic [15:0] retry_lim;
  logic        axi_aw_rdy;
  logic        axi_w_rdy;
  logic        axi_ar_rdy;
  rnb_bid_e    mode;

  assign axi_aw_rdy = ce & ~st_q.aw_got & ~st_q.bvalid;
  assign axi_w_rdy  = ce & ~st_q.w_got & ~st_q.bvalid;
  assign axi_ar_rdy = ce & ~st_q.rvalid;

  always_comb begin
    st_d      = st_q;
    ev        = 4'h0;
    w1c       = 4'h0;
    take_msg  = 1'b0;
    mode      = bid_mode(st_q.bid_addr);
    st_d.tx.start = 1'b0;
    st_d.err      = 1'b0;
    st_d.cts_s1   = cts;
    st_d.cts_s2   = st_q.cts_s1;

    // Slave role never retries
    retry_lim = st_q.ctrl[`RNB_CTRL_SLAVE] ? 16'h0000 :
                st_q.retries;

    // Shared 10 ms tick timer
    if (st_q.tmr != 16'h0000) begin
      if (st_q.pre == TICK_LAST) begin
        st_d.pre = 32'h00000000;
        st_d.tmr = st_q.tmr - 16'h0001;
      end else begin
        st_d.pre = st_q.pre + 32'h00000001;
      end
    end

    net_ok = rx.valid && (rx.net_id == st_q.net_id);
    if (rx.valid && !net_ok)
      ev[`RNB_IRQ_NET_DROP] = 1'b1;

    case (st_q.st)
      RNB_IDLE: begin
        if (st_q.ctrl[`RNB_CTRL_EN]) begin
          if (msg_valid) begin
            take_msg = 1'b1;
          end else if (st_q.bid_act) begin
            st_d = start_bid(st_d, st_q.cur);
          end
        end
      end
      RNB_RTS: begin
        if (st_q.tmr == 16'h0000 && st_q.cts_s2) begin
          st_d.st       = RNB_SEND;
          st_d.tx.start = 1'b1;
          st_d.tx.bid   = st_q.is_bid;
          st_d.tx.addr  = st_q.is_bid ? st_q.cur : 7'h00;
          if (st_q.msg_count != 16'h0000) begin
            if (st_q.sent + 16'h0001 >= st_q.msg_count) begin
              st_d.sent       = 16'h0000;
              st_d.pause_pend = 1'b1;
            end else begin
              st_d.sent = st_q.sent + 16'h0001;
            end
          end
        end
      end
      RNB_SEND: begin
        if (tx_done) begin
          st_d.rts = 1'b0;
          st_d.st  = RNB_REPLY;
          st_d.pre = 32'h00000000;
          st_d.tmr = st_q.resp_time;
        end
      end
      RNB_REPLY: begin
        if (!st_q.is_bid && net_ok && rx.reply) begin
          ev[`RNB_IRQ_MSG_OK] = 1'b1;
          st_d.st = RNB_IDLE;
          if (st_q.bid_act)
            st_d = start_gap(st_d);
        end else if (st_q.tmr == 16'h0000) begin
          if (st_q.is_bid) begin
            st_d = start_gap(st_d);
          end else if (st_q.tries < retry_lim) begin
            st_d.tries = st_q.tries + 16'h0001;
            st_d = begin_tx(st_d);
          end else begin
            st_d.err = 1'b1;
            ev[`RNB_IRQ_MSG_ERR] = 1'b1;
            st_d.st = RNB_IDLE;
            if (st_q.bid_act)
              st_d = start_gap(st_d);
          end
        end
      end
      RNB_GAP: begin
        if (msg_valid) begin
          take_msg = 1'b1;
        end else if (st_q.tmr == 16'h0000) begin
          st_d.st = RNB_IDLE;
          // A cancelled sequence ends here instead of bidding again
          case (st_q.bid_act ? mode : RNB_BID_NONE)
            RNB_BID_DEC: begin
              if (st_q.cur == 7'h00) begin
                st_d.bid_act = 1'b0;
                ev[`RNB_IRQ_BID_END] = 1'b1;
              end else begin
                st_d = start_bid(st_d, st_q.cur - 7'h01);
                st_d.bid_addr = `RNB_BID_DEC_LO +
                                {9'h000, st_q.cur - 7'h01};
              end
            end
            RNB_BID_CONT: st_d = start_bid(st_d, st_q.cur);
            RNB_BID_LOOP: begin
              // Setting register stays untouched here
              st_d = start_bid(st_d, (st_q.cur == 7'h00) ?
                               st_q.base : st_q.cur - 7'h01);
            end
            default: begin
              st_d.bid_act = 1'b0;
              ev[`RNB_IRQ_BID_END] = 1'b1;
            end
          endcase
        end
      end
      RNB_PAUSE: begin
        if (st_q.tmr == 16'h0000) begin
          st_d.pause_pend = 1'b0;
          st_d = begin_tx(st_d);
        end
      end
      default: st_d.st = RNB_IDLE;
    endcase

    if (take_msg) begin
      st_d.is_bid = 1'b0;
      st_d.tries  = 16'h0000;
      // Bid address kept so the sequence resumes after the message
      st_d = begin_tx(st_d);
    end

    // Bus write path
    if (axi_req.awvalid && axi_aw_rdy) begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = axi_req.awaddr[11:0];
    end
    if (axi_req.wvalid && axi_w_rdy) begin
      st_d.w_got  = 1'b1;
      st_d.w_data = axi_req.wdata;
      st_d.w_strb = axi_req.wstrb;
    end
    if (st_q.bvalid && axi_req.bready)
      st_d.bvalid = 1'b0;
    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = 2'b00;
      case (reg_idx({20'h00000, st_q.aw_addr}))
        4'h0: begin
          if (st_q.w_strb[0]) begin
            st_d.ctrl = st_q.w_data[1:0];
            if (st_q.w_data[`RNB_CTRL_SLAVE])
              st_d.bid_act = 1'b0;
            if (st_q.w_data[`RNB_CTRL_EN] &&
                !st_q.ctrl[`RNB_CTRL_EN] &&
                !st_q.w_data[`RNB_CTRL_SLAVE] && mode != RNB_BID_NONE) begin
              st_d.bid_act = 1'b1;
              st_d.base    = bid_base(st_q.bid_addr);
              st_d.cur     = bid_base(st_q.bid_addr);
            end
          end
        end
        4'h1: if (st_q.w_strb[0]) st_d.net_id = st_q.w_data[7:0];
        4'h2: st_d.cts_time = merge16(st_q.cts_time, st_q.w_data,
                                      st_q.w_strb);
        4'h3: st_d.resp_time = merge16(st_q.resp_time, st_q.w_data,
                                       st_q.w_strb);
        4'h4: st_d.bid_gap = merge16(st_q.bid_gap, st_q.w_data,
                                     st_q.w_strb);
        4'h5: st_d.retries = merge16(st_q.retries, st_q.w_data,
                                     st_q.w_strb);
        4'h6: st_d.pause = merge16(st_q.pause, st_q.w_data,
                                   st_q.w_strb);
        4'h7: st_d.msg_count = merge16(st_q.msg_count, st_q.w_data,
                                       st_q.w_strb);
        4'h8: begin
          st_d.bid_addr = merge16(st_q.bid_addr, st_q.w_data,
                                  st_q.w_strb);
          st_d.base    = bid_base(st_d.bid_addr);
          st_d.cur     = bid_base(st_d.bid_addr);
          st_d.bid_act = (bid_mode(st_d.bid_addr) != RNB_BID_NONE) &&
                         !st_q.ctrl[`RNB_CTRL_SLAVE];
        end
        4'h9: st_d.bresp = 2'b00;
        4'ha: if (st_q.w_strb[0]) w1c = st_q.w_data[3:0];
        4'hb: if (st_q.w_strb[0]) st_d.irq_mask = st_q.w_data[3:0];
        default: st_d.bresp = 2'b10;
      endcase
    end

    // Bus read path
    if (st_q.rvalid && axi_req.rready)
      st_d.rvalid = 1'b0;
    if (axi_req.arvalid && axi_ar_rdy) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = 2'b00;
      st_d.rdata  = 32'h00000000;
      case (reg_idx(axi_req.araddr))
        4'h0: st_d.rdata[1:0]  = st_q.ctrl;
        4'h1: st_d.rdata[7:0]  = st_q.net_id;
        4'h2: st_d.rdata[15:0] = st_q.cts_time;
        4'h3: st_d.rdata[15:0] = st_q.resp_time;
        4'h4: st_d.rdata[15:0] = st_q.bid_gap;
        4'h5: st_d.rdata[15:0] = st_q.retries;
        4'h6: st_d.rdata[15:0] = st_q.pause;
        4'h7: st_d.rdata[15:0] = st_q.msg_count;
        4'h8: st_d.rdata[15:0] = st_q.bid_addr;
        4'h9: st_d.rdata = {15'h0000, st_q.bid_act, 1'b0, st_q.cur,
                            st_q.pause_pend, st_q.is_bid, st_q.rts,
                            st_q.cts_s2, 1'b0, st_q.st};
        4'ha: st_d.rdata[3:0] = st_q.irq_stat;
        4'hb: st_d.rdata[3:0] = st_q.irq_mask;
        default: st_d.rresp = 2'b10;
      endcase
    end

    // Sticky events; a new event beats a same-cycle clear
    st_d.irq_stat = (st_q.irq_stat & ~w1c) | ev;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q           <= '0;
      st_q.cts_time  <= `RNB_RST_CTS_TIME;
      st_q.resp_time <= `RNB_RST_RESP_TIME;
      st_q.bid_gap   <= `RNB_RST_BID_GAP;
      st_q.retries   <= `RNB_RST_RETRIES;
      st_q.pause     <= `RNB_RST_PAUSE;
      st_q.msg_count <= `RNB_RST_MSG_COUNT;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign msg_ready       = ce & take_msg;
  assign msg_err         = st_q.err;
  assign rts             = st_q.rts;
  assign tx              = st_q.tx;
  assign irq             = |(st_q.irq_stat & st_q.irq_mask);
  assign axi_rsp.awready = axi_aw_rdy;
  assign axi_rsp.wready  = axi_w_rdy;
  assign axi_rsp.bvalid  = st_q.bvalid;
  assign axi_rsp.bresp   = st_q.bresp;
  assign axi_rsp.arready = axi_ar_rdy;
  assign axi_rsp.rvalid  = st_q.rvalid;
  assign axi_rsp.rdata   = st_q.rdata;
  assign axi_rsp.rresp   = st_q.rresp;

endmodule // rnb_scheduler

// ===== include/rnb_cfg.svh
`ifndef RNB_CFG_SVH
`define RNB_CFG_SVH

// Register byte offsets
`define RNB_OFF_CTRL      12'h000
`define RNB_OFF_NET_ID    12'h004
`define RNB_OFF_CTS_TIME  12'h008
`define RNB_OFF_RESP_TIME 12'h00c
`define RNB_OFF_BID_GAP   12'h010
`define RNB_OFF_RETRIES   12'h014
`define RNB_OFF_PAUSE     12'h018
`define RNB_OFF_MSG_COUNT 12'h01c
`define RNB_OFF_BID_ADDR  12'h020
`define RNB_OFF_STATUS    12'h024
`define RNB_OFF_IRQ_STAT  12'h028
`define RNB_OFF_IRQ_MASK  12'h02c

// Field positions
`define RNB_CTRL_EN       0
`define RNB_CTRL_SLAVE    1
`define RNB_STAT_ADDR_LO  8
`define RNB_STAT_BID_ACT  16
`define RNB_IRQ_MSG_OK    0
`define RNB_IRQ_MSG_ERR   1
`define RNB_IRQ_BID_END   2
`define RNB_IRQ_NET_DROP  3

// Reset values
`define RNB_RST_CTS_TIME  16'h0000
`define RNB_RST_RESP_TIME 16'h0000
`define RNB_RST_BID_GAP   16'h0000
`define RNB_RST_RETRIES   16'h0000
`define RNB_RST_PAUSE     16'h0000
`define RNB_RST_MSG_COUNT 16'h0000

// Bid address setting ranges
`define RNB_BID_SINGLE_LO 16'h0001
`define RNB_BID_DEC_LO    16'h0064
`define RNB_BID_CONT_LO   16'h00c8
`define RNB_BID_LOOP_LO   16'h012c
`define RNB_BID_LIMIT     16'h0190

// Timer tick
`define RNB_TICK_MS       10
`define RNB_CLK_MHZ       100

`endif

// ===== include/rnb_pkg.sv
package rnb_pkg;

  typedef enum logic [2:0] {
    RNB_IDLE, RNB_RTS, RNB_SEND, RNB_REPLY, RNB_GAP, RNB_PAUSE
  } rnb_state_e;

  typedef enum logic [2:0] {
    RNB_BID_NONE, RNB_BID_SINGLE, RNB_BID_DEC, RNB_BID_CONT, RNB_BID_LOOP
  } rnb_bid_e;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } rnb_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rnb_axi_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] net_id;
    logic       reply;
  } rnb_rx_s;

  typedef struct packed {
    logic       start;
    logic       bid;
    logic [6:0] addr;
  } rnb_tx_s;

endpackage

// ===== verif/rnb_modem.sv
`timescale 1ns/10ps
module rnb_modem (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst,
  // Scheduler side
  input wire logic             rts,
  input wire rnb_pkg::rnb_tx_s tx,
  output     logic             cts,
  output     logic             tx_done,
  output     rnb_pkg::rnb_rx_s rx,
  // Behaviour control
  input wire logic [3:0]       lag,
  input wire logic [7:0]       net_id,
  input wire logic             reply_en
);
  import rnb_pkg::*;
  logic [3:0] c_q;
  logic [2:0] d_q;
  logic [4:0] r_q;
  logic       bid_q;
  always_ff @(posedge clk) begin
    tx_done <= 1'b0;
    rx.valid <= 1'b0;
    // Idle rx fields toggle so stale values never look valid
    rx.net_id <= ~rx.net_id;
    rx.reply <= ~rx.reply;
    if (rst) begin
      c_q <= '0;
      d_q <= '0;
      r_q <= '0;
      cts <= 1'b0;
      rx <= '0;
    end else begin
      c_q <= !rts ? 4'h0 : (c_q == lag) ? c_q : c_q + 4'h1;
      cts <= rts && (c_q == lag);
      if (tx.start) begin
        d_q <= 3'h6;
        bid_q <= tx.bid;
      end else if (d_q != 3'h0) begin
        d_q <= d_q - 3'h1;
        if (d_q == 3'h1) begin
          tx_done <= 1'b1;
          r_q <= (reply_en && !bid_q) ? 5'ha : 5'h0;
        end
      end
      if (r_q != 5'h0) begin
        r_q <= r_q - 5'h1;
        if (r_q == 5'h1) begin
          rx.valid <= 1'b1;
          rx.net_id <= net_id;
          rx.reply <= 1'b1;
        end
      end
    end
  end
endmodule // rnb_modem

// ===== verif/rnb_scheduler_monitor.sv
`timescale 1ns/10ps
module rnb_scheduler_monitor #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ce,
  // Register bus
  input wire rnb_pkg::rnb_axi_req_s axi_req,
  input wire rnb_pkg::rnb_axi_rsp_s axi_rsp,
  // Message queue
  input wire logic                  msg_valid,
  input wire logic                  msg_ready,
  input wire logic                  msg_err,
  // Modem link
  input wire logic                  rts,
  input wire logic                  cts,
  input wire rnb_pkg::rnb_tx_s      tx,
  input wire logic                  tx_done,
  input wire rnb_pkg::rnb_rx_s      rx,
  // Interrupt
  input wire logic                  irq
);
  import rnb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_sent;
    tx_done && rts;
  endsequence
  sequence s_cts_low;
    !cts [*4];
  endsequence
  write_answer_a: assert property (s_wr_taken |-> ##[1:2] axi_rsp.bvalid)
    else $error("write response missing");
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
    |-> ##[1:2] axi_rsp.rvalid) else $error("read response missing");
  bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  busy_refuse_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready
    && !axi_rsp.wready) else $error("write accepted while busy");
  start_gate_a: assert property (tx.start |-> rts)
    else $error("frame started without rts");
  cts_gate_a: assert property (s_cts_low |=> !tx.start)
    else $error("frame started without cts");
  rts_drop_a: assert property (s_sent |-> ##[1:2] !rts)
    else $error("rts held after frame end");
  start_pulse_a: assert property (tx.start |=> !tx.start)
    else $error("start longer than one cycle");
  bid_range_a: assert property (tx.start && tx.bid |-> tx.addr <= 7'd99)
    else $error("bid address out of range");
  plain_addr_a: assert property (tx.start && !tx.bid |-> tx.addr == 7'd0)
    else $error("ordinary frame with address");
  take_only_a: assert property (msg_ready |-> msg_valid && ce)
    else $error("message taken while none queued");
  err_pulse_a: assert property (msg_err |=> !msg_err)
    else $error("error pulse too long");
endmodule // rnb_scheduler_monitor

bind rnb_scheduler rnb_scheduler_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (
  .clk(clk), .rst(rst), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_err(msg_err),
  .rts(rts), .cts(cts), .tx(tx), .tx_done(tx_done), .rx(rx), .irq(irq));

// ===== verif/rnb_scheduler_test.sv
`timescale 1ns/10ps
`include "rnb_cfg.svh"
module rnb_scheduler_test;
  import rnb_pkg::*;
  localparam int TK = 4;
  logic         clk, rst, ce, msg_valid, msg_ready, msg_err, rts, cts;
  logic         tx_done, irq, m_rep, rts_d;
  rnb_axi_req_s req;
  rnb_axi_rsp_s rsp;
  rnb_tx_s      tx;
  rnb_rx_s      rx;
  logic [7:0]   m_id;
  logic [3:0]   m_lag;
  logic [31:0]  d;
  logic [1:0]   r;
  logic [7:0]   txa[$];
  int           tq[$];
  int           failures, n_compared, cyc, t_rts, t_mr;

  rnb_scheduler #(.TICK_CYCLES(TK)) i_rnb_scheduler (.clk(clk), .rst(rst),
    .ce(ce), .axi_req(req), .axi_rsp(rsp), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_err(msg_err), .rts(rts), .cts(cts),
    .tx(tx), .tx_done(tx_done), .rx(rx), .irq(irq));
  rnb_modem i_rnb_modem (.clk(clk), .rst(rst), .rts(rts), .tx(tx),
    .cts(cts), .tx_done(tx_done), .rx(rx), .lag(m_lag), .net_id(m_id),
    .reply_en(m_rep));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    rts_d <= rts;
    if (rts && !rts_d) t_rts <= cyc;
    if (tx.start === 1'b1) begin
      txa.push_back({tx.bid, tx.addr});
      tq.push_back(cyc);
    end
  end

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ap, wp;
    @(posedge clk);
    ap = 1'b1;
    wp = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr <= {20'h0, a};
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (ap || wp) begin
      @(posedge clk);
      if (rsp.awready === 1'b1) begin ap = 1'b0; req.awvalid <= 1'b0; end
      if (rsp.wready === 1'b1) begin wp = 1'b0; req.wvalid <= 1'b0; end
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= {20'h0, a};
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic send;
    @(posedge clk);
    msg_valid <= 1'b1;
    do @(posedge clk); while (msg_ready !== 1'b1);
    t_mr = cyc;
    msg_valid <= 1'b0;
  endtask

  task automatic poll(input int b);
    do rd(`RNB_OFF_IRQ_STAT); while (d[b] !== 1'b1);
  endtask

  task automatic ntx(input int n);
    while (txa.size() < n) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    stop_test;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    msg_valid = 1'b0;
    req = '0;
    m_id = 8'h5a;
    m_rep = 1'b1;
    m_lag = 4'h2;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 'h2c; a += 4) begin
      rd(12'(a));
      ck(d, 32'h0);
    end
    rd(12'h030);
    ck({30'h0, r}, 32'h2);
    ck(d, 32'h0);
    rd(12'h006);
    ck({30'h0, r}, 32'h2);
    wr(`RNB_OFF_NET_ID, 32'h15a);
    rd(`RNB_OFF_NET_ID);
    ck(d, 32'h5a);
    wr(`RNB_OFF_PAUSE, 32'hffff);
    rd(`RNB_OFF_PAUSE);
    ck(d, 32'hffff);
    wr(`RNB_OFF_PAUSE, 32'ha);
    wr(`RNB_OFF_CTS_TIME, 32'h5);
    wr(`RNB_OFF_RESP_TIME, 32'h14);
    wr(`RNB_OFF_BID_GAP, 32'h5);
    wr(`RNB_OFF_RETRIES, 32'h2);
    wr(`RNB_OFF_IRQ_MASK, 32'hf);
    wr(`RNB_OFF_CTRL, 32'h1);
    // Matching network, answered at once
    send;
    poll(0);
    ck(32'(t_rts - t_mr <= 2), 32'h1);
    ck(32'(tq[0] - t_rts >= 4 * TK), 32'h1);
    ck(32'(txa.size()), 32'h1);
    wr(`RNB_OFF_IRQ_STAT, 32'h1);
    // Foreign network: every reply dropped, retries run out
    m_id <= 8'h33;
    m_lag <= 4'ha;
    txa.delete();
    send;
    do @(posedge clk); while (msg_err !== 1'b1);
    ck(32'(txa.size()), 32'h3);
    rd(`RNB_OFF_IRQ_STAT);
    ck(d, 32'ha);
    ck({31'h0, irq}, 32'h1);
    wr(`RNB_OFF_IRQ_MASK, 32'h0);
    ck({31'h0, irq}, 32'h0);
    wr(`RNB_OFF_IRQ_MASK, 32'hf);
    wr(`RNB_OFF_IRQ_STAT, 32'hf);
    ck({31'h0, irq}, 32'h0);
    // Transmitter rest after one frame
    m_id <= 8'h5a;
    m_lag <= 4'h2;
    wr(`RNB_OFF_MSG_COUNT, 32'h1);
    send;
    poll(0);
    wr(`RNB_OFF_IRQ_STAT, 32'h1);
    send;
    poll(0);
    ck(32'(t_rts - t_mr >= 9 * TK), 32'h1);
    ck(32'(t_rts - t_mr <= 11 * TK + 4), 32'h1);
    wr(`RNB_OFF_MSG_COUNT, 32'h0);
    wr(`RNB_OFF_IRQ_STAT, 32'hf);
    // Single bid, and a decrementing run from address 0
    for (int k = 0; k < 2; k++) begin
      txa.delete();
      wr(`RNB_OFF_BID_ADDR, k ? 32'd100 : 32'd5);
      poll(2);
      repeat (150) @(posedge clk);
      ck(32'(txa.size()), 32'h1);
      ck({24'h0, txa[0]}, k ? 32'h80 : 32'h85);
      wr(`RNB_OFF_IRQ_STAT, 32'hf);
    end
    // Decrementing run
    txa.delete();
    wr(`RNB_OFF_BID_ADDR, 32'd102);
    ntx(2);
    rd(`RNB_OFF_BID_ADDR);
    ck(d, 32'd101);
    poll(2);
    ck({8'h0, txa[0], txa[1], txa[2]}, 32'h828180);
    ck(32'(txa.size()), 32'h3);
    wr(`RNB_OFF_IRQ_STAT, 32'hf);
    // Continuous bids with a queued message
    txa.delete();
    tq.delete();
    wr(`RNB_OFF_BID_ADDR, 32'd203);
    ntx(1);
    send;
    ck(32'(t_mr - tq[0] >= 19 * TK), 32'h1);
    ntx(4);
    ck({txa[0], txa[1], txa[2], txa[3]}, 32'h83008383);
    ck(32'(tq[3] - tq[2] >= 23 * TK), 32'h1);
    ck(32'(tq[3] - tq[2] <= 40 * TK), 32'h1);
    wr(`RNB_OFF_BID_ADDR, 32'h0);
    poll(2);
    wr(`RNB_OFF_IRQ_STAT, 32'hf);
    // Looping run keeps its setting visible
    txa.delete();
    wr(`RNB_OFF_BID_ADDR, 32'd301);
    ntx(5);
    rd(`RNB_OFF_BID_ADDR);
    ck(d, 32'd301);
    ck({txa[1], txa[2], txa[3], txa[4]}, 32'h80818081);
    ck({24'h0, txa[0]}, 32'h81);
    // Slave role never retries
    wr(`RNB_OFF_CTRL, 32'h3);
    m_id <= 8'h33;
    repeat (300) @(posedge clk);
    txa.delete();
    send;
    do @(posedge clk); while (msg_err !== 1'b1);
    ck(32'(txa.size()), 32'h1);
    stop_test;
  end
endmodule // rnb_scheduler_test
